// file: wit_watchdog_timer.sv
// watchdog / interval timer with settle-time select register
`timescale 1ns/1ps

// Functional notes
// - period select 0-6 gives 2^12..2^18 cycles, 7 gives 2^20.
// - mode bit 0 means interval irq; 1 means nmi or reset per action bit.
// - writing run=1 clears counter above the prescaler and starts; run cannot be cleared.
// - mode and action bits stick at 1 until reset.
// - restart keeps low 2^8 prescaler, first period may be shorter.
// - counting goes on in halt, pauses in stop mode.
// - counting pauses while cpu runs from subsystem clock.
// - interval mode raises an interrupt every elapsed period.
// - interval interrupt gated by its mask, carries its priority flag.
// - settle select 0 gives 2^12, 1-4 give 2^14..2^17 cycles.
// - settle select resets to 4, so reset-driven wait is 2^17.
module wit_watchdog_timer
	import wit_pkg::*;
#(
	parameter int unsigned SHRINK = 0
) (
	input  wire logic        sys_clk,
	input  wire logic        rst,
	input  wire logic [15:0] regAddr,
	input  wire logic        regWrEn,
	input  wire logic [7:0]  regWrData,
	input  wire logic        regRdEn,
	output logic      [7:0]  regRdData,
	input  wire logic        stopMode,
	input  wire logic        subClkSel,
	input  wire logic        stopRelease,
	input  wire logic        intervalIrqMask,
	input  wire logic        intervalIrqPriority,
	output logic             intervalIrq,
	output logic             intervalIrqPrioOut,
	output logic             nmiReq,
	output logic             resetReq,
	output logic             counting,
	output logic             oscStable
);

	localparam logic [CNT_W-1:0] PRE_MASK =
		CNT_W'((64'h1 << (PRE_EXP - int'(SHRINK))) - 64'h1);

	logic [2:0]       periodSelReg;
	logic [2:0]       periodSelNext;
	logic [2:0]       settleSelReg;
	logic [2:0]       settleSelNext;
	logic             runReg;
	logic             runNext;
	logic             guardModeReg;
	logic             guardModeNext;
	logic             actionReg;
	logic             actionNext;
	logic [7:0]       rdDataReg;
	logic [7:0]       rdDataNext;
	logic [CNT_W-1:0] cntReg;
	logic [CNT_W-1:0] cntNext;
	logic [CNT_W-1:0] ovfMask;
	logic             irqReg;
	logic             irqNext;
	logic             prioReg;
	logic             prioNext;
	logic             nmiReg;
	logic             nmiNext;
	logic             resetReg;
	logic             resetNext;
	logic             countingReg;
	logic             countingNext;
	logic             periodWr;
	logic             modeWr;
	logic             settleWr;
	logic             restart;
	logic             countEn;
	logic             ovf;
	int               ovfExp;

	// ------------------------------------------------------------
	// register access
	// ------------------------------------------------------------
	// byte writes by address
	assign periodWr = regWrEn && (regAddr == PERIOD_SEL_ADDR);
	assign modeWr   = regWrEn && (regAddr == MODE_CTRL_ADDR);
	assign settleWr = regWrEn && (regAddr == SETTLE_SEL_ADDR);
	assign restart  = modeWr && regWrData[RUN_BIT];

	// next register values; reserved bits never stored
	always_comb begin
		periodSelNext = periodSelReg;
		settleSelNext = settleSelReg;
		if (periodWr) begin
			periodSelNext = regWrData[SEL_MSB:0];
		end
		if (settleWr) begin
			settleSelNext = regWrData[SEL_MSB:0];
		end
		runNext       = runReg | restart;
		guardModeNext = guardModeReg |
			(modeWr & regWrData[GUARD_MODE_BIT]);
		actionNext    = actionReg |
			(modeWr & regWrData[ACTION_BIT]);
	end

	// read data, unmapped and reserved bits read zero
	always_comb begin
		rdDataNext = rdDataReg;
		if (regRdEn) begin
			rdDataNext = READ_ZERO;
			case (regAddr)
				PERIOD_SEL_ADDR: begin
					rdDataNext[SEL_MSB:0] = periodSelReg;
				end
				MODE_CTRL_ADDR: begin
					rdDataNext[RUN_BIT]        = runReg;
					rdDataNext[GUARD_MODE_BIT] = guardModeReg;
					rdDataNext[ACTION_BIT]     = actionReg;
				end
				SETTLE_SEL_ADDR: begin
					rdDataNext[SEL_MSB:0] = settleSelReg;
				end
				default: begin
					rdDataNext = READ_ZERO;
				end
			endcase
		end
	end

	// register file flops
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			periodSelReg <= PERIOD_SEL_RST;
			settleSelReg <= SETTLE_SEL_RST;
			runReg       <= 1'b0;
			guardModeReg <= 1'b0;
			actionReg    <= 1'b0;
			rdDataReg    <= READ_ZERO;
		end else begin
			periodSelReg <= periodSelNext;
			settleSelReg <= settleSelNext;
			runReg       <= runNext;
			guardModeReg <= guardModeNext;
			actionReg    <= actionNext;
			rdDataReg    <= rdDataNext;
		end
	end

	// ------------------------------------------------------------
	// counter and overflow
	// ------------------------------------------------------------
	// halt keeps counting; stop and subsystem clock freeze it
	assign countEn = runReg && !stopMode && !subClkSel;

	// overflow is the carry out of the selected bit
	always_comb begin
		ovfExp  = wit_period_exp(periodSelReg) - int'(SHRINK);
		ovfMask = CNT_W'((64'h1 << ovfExp) - 64'h1);
		cntNext = cntReg;
		if (countEn) begin
			cntNext = cntReg + CNT_W'(1);
		end
		if (restart) begin
			cntNext = cntNext & PRE_MASK;
		end
		// a restart in the overflow cycle services the watchdog
		ovf = countEn && !restart && ((cntReg & ovfMask) == ovfMask);
	end

	// one-cycle overflow requests routed by mode
	always_comb begin
		irqNext      = ovf && !guardModeReg && !intervalIrqMask;
		prioNext     = intervalIrqPriority;
		nmiNext      = ovf && guardModeReg && !actionReg;
		resetNext    = ovf && guardModeReg && actionReg;
		countingNext = countEn;
	end

	// counter and request flops
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			cntReg      <= '0;
			irqReg      <= 1'b0;
			prioReg     <= 1'b0;
			nmiReg      <= 1'b0;
			resetReg    <= 1'b0;
			countingReg <= 1'b0;
		end else begin
			cntReg      <= cntNext;
			irqReg      <= irqNext;
			prioReg     <= prioNext;
			nmiReg      <= nmiNext;
			resetReg    <= resetNext;
			countingReg <= countingNext;
		end
	end

	assign regRdData          = rdDataReg;
	assign intervalIrq        = irqReg;
	assign intervalIrqPrioOut = prioReg;
	assign nmiReq             = nmiReg;
	assign resetReq           = resetReg;
	assign counting           = countingReg;

	// ------------------------------------------------------------
	// settle timer
	// ------------------------------------------------------------
	// wait restarts on stop release, sized by the settle select
	wit_osc_settle #(
		.SHRINK      (SHRINK)
	) settleTimer (
		.sys_clk     (sys_clk),
		.rst         (rst),
		.settleStart (stopRelease),
		.settleSel   (settleSelReg),
		.oscStable   (oscStable)
	);

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	AST_OVF_ALIGN: assert property (@(posedge sys_clk) disable iff (rst)
		(nmiReq || resetReq || intervalIrq) && $stable(periodSelReg)
		|-> (cntReg & ovfMask) == '0)
		else $error("overflow request not on a period boundary");

	AST_NMI_CAUSE: assert property (@(posedge sys_clk) disable iff (rst)
		nmiReq |-> $past(guardModeReg) && !$past(actionReg) && !resetReq &&
		!intervalIrq)
		else $error("nmi request outside watchdog nmi mode");

	AST_RESET_CAUSE: assert property (@(posedge sys_clk) disable iff (rst)
		resetReq |-> guardModeReg && actionReg && !nmiReq)
		else $error("reset request outside watchdog reset mode");

	AST_RESTART: assert property (@(posedge sys_clk) disable iff (rst)
		restart |=> runReg && (cntReg & ~PRE_MASK) == '0)
		else $error("run write did not clear the counter");

	AST_RUN_STICKY: assert property (@(posedge sys_clk) disable iff (rst)
		runReg |=> runReg [*2])
		else $error("run bit cleared without reset");

	AST_MODE_STICKY: assert property (@(posedge sys_clk) disable iff (rst)
		!($fell(guardModeReg) || $fell(actionReg)))
		else $error("mode bit cleared without reset");

	AST_FREEZE: assert property (@(posedge sys_clk) disable iff (rst)
		(stopMode || subClkSel) && !restart |=> $stable(cntReg))
		else $error("counter moved in stop or on subsystem clock");

	AST_IRQ_GATE: assert property (@(posedge sys_clk) disable iff (rst)
		intervalIrq |-> !$past(guardModeReg) && !$past(intervalIrqMask))
		else $error("interval irq raised while masked or in watchdog mode");

	AST_RESERVED_ZERO: assert property (@(posedge sys_clk) disable iff (rst)
		$past(regRdEn) && $past(regAddr) != MODE_CTRL_ADDR
		|-> regRdData[7:3] == 5'h00)
		else $error("reserved bits read nonzero");

	AST_SETTLE_RESET: assert property (@(posedge sys_clk)
		$past(rst) && !rst |-> settleSelReg == SETTLE_SEL_RST)
		else $error("settle select not at its reset value");

	// ------------------------------------------------------------
	// request pulse and register load checks
	// ------------------------------------------------------------
	// every request lasts exactly one cycle
	AST_IRQ_PULSE: assert property (@(posedge sys_clk) disable iff (rst)
		intervalIrq |=> !intervalIrq)
		else $error("interval irq longer than one cycle");

	AST_NMI_PULSE: assert property (@(posedge sys_clk) disable iff (rst)
		nmiReq |=> !nmiReq)
		else $error("nmi request longer than one cycle");

	AST_RESET_PULSE: assert property (@(posedge sys_clk) disable iff (rst)
		resetReq |=> !resetReq)
		else $error("reset request longer than one cycle");

	// run and mode bits only rise from a software write
	AST_RUN_SOURCE: assert property (@(posedge sys_clk) disable iff (rst)
		$rose(runReg) |-> $past(restart))
		else $error("run bit set without a run write");

	AST_GUARD_SOURCE: assert property (@(posedge sys_clk) disable iff (rst)
		$rose(guardModeReg) |-> $past(modeWr))
		else $error("watchdog mode set without a mode write");

	// select registers keep the low three write bits only
	AST_PERIOD_LOAD: assert property (@(posedge sys_clk) disable iff (rst)
		$past(periodWr) && !$past(rst)
		|-> {5'h00, periodSelReg} == ($past(regWrData) & 8'h07))
		else $error("period select not loaded from the write");

	AST_SETTLE_LOAD: assert property (@(posedge sys_clk) disable iff (rst)
		$past(settleWr) && !$past(rst)
		|-> {5'h00, settleSelReg} == ($past(regWrData) & 8'h07))
		else $error("settle select not loaded from the write");

	// the priority flag follows its input one cycle late
	AST_PRIO_FOLLOW: assert property (@(posedge sys_clk) disable iff (rst)
		!$past(rst) |-> intervalIrqPrioOut == $past(intervalIrqPriority))
		else $error("priority flag not passed on");

endmodule

// file: wit_pkg.sv
// constants shared by the watchdog / interval timer and its settle timer
package wit_pkg;

	// ------------------------------------------------------------
	// register addresses
	// ------------------------------------------------------------
	localparam logic [15:0] PERIOD_SEL_ADDR = 16'hff42;
	localparam logic [15:0] MODE_CTRL_ADDR  = 16'hfff9;
	localparam logic [15:0] SETTLE_SEL_ADDR = 16'hfffa;

	// ------------------------------------------------------------
	// field positions and reset values
	// ------------------------------------------------------------
	localparam int          RUN_BIT        = 7;
	localparam int          GUARD_MODE_BIT = 4;
	localparam int          ACTION_BIT     = 3;
	localparam int          SEL_MSB        = 2;
	localparam logic [2:0]  PERIOD_SEL_RST = 3'h0;
	localparam logic [2:0]  SETTLE_SEL_RST = 3'h4;
	localparam logic [7:0]  READ_ZERO      = 8'h00;

	// ------------------------------------------------------------
	// counter geometry and period exponents (cycles = 2**exp)
	// ------------------------------------------------------------
	localparam int          CNT_W           = 20;
	localparam int          PRE_EXP         = 8;
	localparam logic [2:0]  PERIOD_SEL_LONG = 3'h7;
	localparam int          PERIOD_EXP_MIN  = 12;
	localparam int          PERIOD_EXP_LONG = 20;
	localparam int          SETTLE_CNT_W    = 17;
	localparam logic [2:0]  SETTLE_SEL_MAX  = 3'h4;
	localparam int          SETTLE_EXP_MIN  = 12;
	localparam int          SETTLE_EXP_BASE = 13;
	localparam int          SETTLE_EXP_MAX  = 17;

	// overflow exponent for a period select code
	function automatic int wit_period_exp(input logic [2:0] sel);
		if (sel == PERIOD_SEL_LONG) begin
			return PERIOD_EXP_LONG;
		end
		return PERIOD_EXP_MIN + int'(sel);
	endfunction

	// settle exponent; prohibited codes fall back to the longest wait
	function automatic int wit_settle_exp(input logic [2:0] sel);
		if (sel == 3'h0) begin
			return SETTLE_EXP_MIN;
		end
		if (sel > SETTLE_SEL_MAX) begin
			return SETTLE_EXP_MAX;
		end
		return SETTLE_EXP_BASE + int'(sel);
	endfunction

endpackage

// file: wit_osc_settle.sv
// oscillation settle wait timer after reset or stop release
`timescale 1ns/1ps

module wit_osc_settle
	import wit_pkg::*;
#(
	parameter int unsigned SHRINK = 0
) (
	input  wire logic       sys_clk,
	input  wire logic       rst,
	input  wire logic       settleStart,
	input  wire logic [2:0] settleSel,
	output logic            oscStable
);

	typedef enum logic [0:0] {
		SETTLE_WAIT = 1'b0,
		SETTLE_DONE = 1'b1
	} wit_settle_state_t;

	wit_settle_state_t              stateReg;
	wit_settle_state_t              stateNext;
	logic [SETTLE_CNT_W-1:0]        cntReg;
	logic [SETTLE_CNT_W-1:0]        cntNext;
	logic [SETTLE_CNT_W-1:0]        lastCnt;
	int                             settleExp;

	// ------------------------------------------------------------
	// wait sequencing
	// ------------------------------------------------------------
	// count 2**exp cycles, restart on every stop release
	always_comb begin
		settleExp = wit_settle_exp(settleSel) - int'(SHRINK);
		lastCnt   = SETTLE_CNT_W'((64'h1 << settleExp) - 64'h1);
		stateNext = stateReg;
		cntNext   = cntReg;
		case (stateReg)
			SETTLE_WAIT: begin
				cntNext = cntReg + SETTLE_CNT_W'(1);
				if (cntReg == lastCnt) begin
					stateNext = SETTLE_DONE;
				end
			end
			SETTLE_DONE: begin
				cntNext = '0;
			end
			default: begin
				stateNext = SETTLE_WAIT;
				cntNext   = '0;
			end
		endcase
		if (settleStart) begin
			stateNext = SETTLE_WAIT;
			cntNext   = '0;
		end
	end

	// reset release itself starts a wait
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			stateReg <= SETTLE_WAIT;
			cntReg   <= '0;
		end else begin
			stateReg <= stateNext;
			cntReg   <= cntNext;
		end
	end

	assign oscStable = (stateReg == SETTLE_DONE);

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	AST_SETTLE_LEN: assert property (@(posedge sys_clk) disable iff (rst)
		$rose(oscStable) && $stable(settleSel) |-> $past(cntReg) == lastCnt)
		else $error("settle wait ended at wrong count");

	AST_SETTLE_RESTART: assert property (@(posedge sys_clk) disable iff (rst)
		settleStart |=> !oscStable [*2])
		else $error("stop release did not restart the settle wait");

endmodule

// file: wit_watchdog_timer_bench.sv
// self-checking testbench for the watchdog / interval timer
`timescale 1ns/1ps

module wit_watchdog_timer_bench;
	import wit_pkg::*;

	localparam int SH = 6;

	logic        sys_clk;
	logic        rst;
	logic [15:0] regAddr;
	logic        regWrEn;
	logic [7:0]  regWrData;
	logic        regRdEn;
	logic [7:0]  regRdData;
	logic        stopMode;
	logic        subClkSel;
	logic        stopRelease;
	logic        intervalIrqMask;
	logic        intervalIrqPriority;
	logic        intervalIrq;
	logic        intervalIrqPrioOut;
	logic        nmiReq;
	logic        resetReq;
	logic        counting;
	logic        oscStable;
	int          errorCnt;
	int          comparisons;
	int          irqCnt;
	int          nmiCnt;
	int          n;
	int          p;
	int          snap;
	int          sExp [6] = '{12, 14, 15, 16, 17, 17};

	wit_watchdog_timer #(.SHRINK(SH)) dut (
		.sys_clk             (sys_clk),
		.rst                 (rst),
		.regAddr             (regAddr),
		.regWrEn             (regWrEn),
		.regWrData           (regWrData),
		.regRdEn             (regRdEn),
		.regRdData           (regRdData),
		.stopMode            (stopMode),
		.subClkSel           (subClkSel),
		.stopRelease         (stopRelease),
		.intervalIrqMask     (intervalIrqMask),
		.intervalIrqPriority (intervalIrqPriority),
		.intervalIrq         (intervalIrq),
		.intervalIrqPrioOut  (intervalIrqPrioOut),
		.nmiReq              (nmiReq),
		.resetReq            (resetReq),
		.counting            (counting),
		.oscStable           (oscStable)
	);

	// ------------------------------------------------------------
	// clock and pulse counters
	// ------------------------------------------------------------
	always #2.5 sys_clk = ~sys_clk;

	// count request pulses mid-cycle, clear of the launching edge
	always @(negedge sys_clk) begin
		if (intervalIrq === 1'b1) irqCnt++;
		if (nmiReq === 1'b1) nmiCnt++;
	end

	// ------------------------------------------------------------
	// checks and bus tasks
	// ------------------------------------------------------------
	task automatic stopTest;
		$display("errors %0d comparisons %0d", errorCnt, comparisons);
		if (errorCnt == 0 && comparisons > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	task automatic chk8(input logic [7:0] got, input logic [7:0] exp,
			input string m);
		comparisons++;
		if (got !== exp) begin
			errorCnt++;
			$display("BAD %0t %s got %h exp %h", $time, m, got, exp);
		end
	endtask

	task automatic chk1(input logic got, input logic exp, input string m);
		comparisons++;
		if (got !== exp) begin
			errorCnt++;
			$display("BAD %0t %s got %b", $time, m, got);
		end
	endtask

	task automatic chkRng(input int got, input int lo, input int hi,
			input string m);
		comparisons++;
		if (got < lo || got > hi) begin
			errorCnt++;
			$display("BAD %0t %s got %0d want %0d..%0d", $time, m, got, lo, hi);
		end
	endtask

	// one byte write, strobe held for one edge
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		regAddr   <= a;
		regWrData <= d;
		regWrEn   <= 1'b1;
		@(posedge sys_clk);
		regWrEn   <= 1'b0;
	endtask

	// one byte read, data checked 1 ns after the edge that samples the strobe
	task automatic rd(input logic [15:0] a, input logic [7:0] e);
		@(posedge sys_clk);
		regAddr <= a;
		regRdEn <= 1'b1;
		@(posedge sys_clk);
		regRdEn <= 1'b0;
		#1;
		chk8(regRdData, e, "read data");
	endtask

	function automatic logic pick(input int w);
		case (w)
			0: return intervalIrq;
			1: return nmiReq;
			2: return resetReq;
			default: return oscStable;
		endcase
	endfunction

	// edges until the chosen output is high, -1 when it never comes
	task automatic waitPulse(input int w, output int c);
		for (c = 1; c <= 20000; c++) begin
			@(posedge sys_clk);
			#1;
			if (pick(w) === 1'b1) return;
		end
		c = -1;
	endtask

	task automatic doReset;
		@(posedge sys_clk);
		rst <= 1'b1;
		repeat (3) @(posedge sys_clk);
		rst <= 1'b0;
	endtask

	// ------------------------------------------------------------
	// watchdog against hangs
	// ------------------------------------------------------------
	initial begin
		repeat (80000) @(posedge sys_clk);
		errorCnt++;
		$display("BAD %0t timeout", $time);
		stopTest();
	end

	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		sys_clk = 1'b0; rst = 1'b1; regAddr = 16'h0000; regWrEn = 1'b0;
		regWrData = 8'h00; regRdEn = 1'b0; stopMode = 1'b0;
		subClkSel = 1'b0; stopRelease = 1'b0; intervalIrqMask = 1'b0;
		intervalIrqPriority = 1'b0; errorCnt = 0; comparisons = 0;
		irqCnt = 0; nmiCnt = 0;
		repeat (3) @(posedge sys_clk);
		rst <= 1'b0;
		waitPulse(3, n);
		chkRng(n, (1 << (17 - SH)) - 1, (1 << (17 - SH)) + 2, "reset settle");
		// reset values, reserved bits and an unmapped place
		rd(PERIOD_SEL_ADDR, 8'h00);
		rd(MODE_CTRL_ADDR, 8'h00);
		rd(SETTLE_SEL_ADDR, 8'h04);
		wr(16'h1234, 8'hff);
		rd(16'h1234, 8'h00);
		wr(PERIOD_SEL_ADDR, 8'hff);
		rd(PERIOD_SEL_ADDR, 8'h07);
		wr(SETTLE_SEL_ADDR, 8'hff);
		rd(SETTLE_SEL_ADDR, 8'h07);
		// settle codes 0 to 5, the last one prohibited
		for (int c = 0; c < 6; c++) begin
			wr(SETTLE_SEL_ADDR, 8'(c));
			@(posedge sys_clk);
			stopRelease <= 1'b1;
			@(posedge sys_clk);
			stopRelease <= 1'b0;
			waitPulse(3, n);
			p = 1 << (sExp[c] - SH);
			chkRng(n, p - 1, p + 2, "settle wait");
		end
		// interval mode, every period code, first and steady period
		for (int c = 0; c < 8; c++) begin
			p = 1 << ((c == 7 ? 20 : 12 + c) - SH);
			wr(PERIOD_SEL_ADDR, 8'(c));
			wr(MODE_CTRL_ADDR, 8'h80);
			waitPulse(0, n);
			chkRng(n, p - (1 << (8 - SH)), p + 2, "first period");
			waitPulse(0, n);
			chkRng(n, p, p, "steady period");
		end
		wr(MODE_CTRL_ADDR, 8'h00);
		rd(MODE_CTRL_ADDR, 8'h80);
		@(posedge sys_clk);
		intervalIrqPriority <= 1'b1;
		repeat (2) @(posedge sys_clk);
		#1;
		chk1(intervalIrqPrioOut, 1'b1, "priority out");
		// masked interval request stays quiet
		wr(PERIOD_SEL_ADDR, 8'h00);
		wr(MODE_CTRL_ADDR, 8'h80);
		intervalIrqMask <= 1'b1;
		snap = irqCnt;
		repeat (200) @(posedge sys_clk);
		chkRng(irqCnt, snap, snap, "masked irq");
		intervalIrqMask <= 1'b0;
		// stop mode, then subsystem clock, freeze the count
		for (int k = 0; k < 2; k++) begin
			wr(MODE_CTRL_ADDR, 8'h80);
			if (k == 0) stopMode <= 1'b1;
			else subClkSel <= 1'b1;
			snap = irqCnt;
			repeat (300) @(posedge sys_clk);
			#1;
			chk1(counting, 1'b0, "frozen count");
			chkRng(irqCnt, snap, snap, "irq while frozen");
			@(posedge sys_clk);
			stopMode  <= 1'b0;
			subClkSel <= 1'b0;
			waitPulse(0, n);
			chkRng(n, 64 - 6, 64 + 2, "resume period");
			chk1(counting, 1'b1, "counting again");
		end
		// watchdog with nmi, kept alive then starved
		doReset();
		rd(MODE_CTRL_ADDR, 8'h00);
		wr(MODE_CTRL_ADDR, 8'h90);
		wr(MODE_CTRL_ADDR, 8'h80);
		rd(MODE_CTRL_ADDR, 8'h90);
		snap = nmiCnt + irqCnt;
		repeat (10) begin
			wr(MODE_CTRL_ADDR, 8'h90);
			repeat (30) @(posedge sys_clk);
		end
		chkRng(nmiCnt + irqCnt, snap, snap, "kept alive");
		wr(MODE_CTRL_ADDR, 8'h90);
		waitPulse(1, n);
		chkRng(n, 64 - 4, 64 + 2, "nmi overflow");
		// watchdog with reset action
		doReset();
		wr(MODE_CTRL_ADDR, 8'h98);
		waitPulse(2, n);
		chkRng(n, 64 - 4, 64 + 2, "reset overflow");
		stopTest();
	end

endmodule
